// file: shared/serial_port_map.vh
// Register offsets, field positions, reset values and mode codes of the serial port.
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
`define OFF_STATUS 12'h018F
`define OFF_CTRL1 12'h0190
`define OFF_CTRL2 12'h0191
`define OFF_EVENT 12'h01A0
`define CTRL1_RESET 8'h00
`define STATUS_RESET 8'h00
`define CTRL2_RESET 8'h00
`define BIT_WRITE_COLLISION_FLAG 7
`define BIT_OVF 6
`define BIT_EN 5
`define BIT_CKP 4
`define BIT_STOPDET 4
`define BIT_STARTDET 3
`define BIT_RW 2
`define BIT_UA 1
`define BIT_BF 0
`define BIT_ACK_SEQUENCE_REQUEST_BIT 4
`define BIT_RECEIVE_REQUEST_BIT 3
`define BIT_PEN 2
`define BIT_REPEATED_START_REQUEST_BIT 1
`define BIT_SEN 0
`define MODE_SPI_H4 4'h0
`define MODE_SPI_H16 4'h1
`define MODE_SPI_H64 4'h2
`define MODE_SPI_HT2 4'h3
`define MODE_SPI_C_SS 4'h4
`define MODE_SPI_C 4'h5
`define MODE_I2C_C7 4'h6
`define MODE_I2C_C10 4'h7
`define MODE_I2C_H 4'h8
`define MODE_SPI_HDIV 4'hA
`define MODE_I2C_FW 4'hB
`define MODE_I2C_C7SP 4'hE
`define MODE_I2C_C10SP 4'hF
`define CLK_SEL_DIV4 3'h0
`define CLK_SEL_DIV16 3'h1
`define CLK_SEL_DIV64 3'h2
`define CLK_SEL_TMR 3'h3
`define CLK_SEL_BAUD 3'h4
`define CLK_SEL_PIN 3'h5
`define CLK_SEL_NONE 3'h7
`endif

// file: rtl/port_mode_decode.v
// Decoder of the four-bit port mode select into mode classes.
`timescale 1ns/1ps
`include "serial_port_map.vh"
module port_mode_decode (
  // Mode select.
  input wire [3:0] portModeSelect,
  // Decoded classes.
  output reg isSpi,
  output reg isSpiHost,
  output reg isSpiClient,
  output reg slaveSelectUsed,
  output reg isI2cHost,
  output reg isI2cClient,
  output reg isTenBit,
  output reg startStopIrq,
  output reg isReserved,
  output reg [2:0] clockSource
);
  always @* begin
    isSpi = 1'b0;
    isSpiHost = 1'b0;
    isSpiClient = 1'b0;
    slaveSelectUsed = 1'b0;
    isI2cHost = 1'b0;
    isI2cClient = 1'b0;
    isTenBit = 1'b0;
    startStopIrq = 1'b0;
    isReserved = 1'b0;
    clockSource = `CLK_SEL_NONE;
    case (portModeSelect)
      `MODE_SPI_H4: begin
        isSpi = 1'b1;
        isSpiHost = 1'b1;
        clockSource = `CLK_SEL_DIV4;
      end
      `MODE_SPI_H16: begin
        isSpi = 1'b1;
        isSpiHost = 1'b1;
        clockSource = `CLK_SEL_DIV16;
      end
      `MODE_SPI_H64: begin
        isSpi = 1'b1;
        isSpiHost = 1'b1;
        clockSource = `CLK_SEL_DIV64;
      end
      `MODE_SPI_HT2: begin
        isSpi = 1'b1;
        isSpiHost = 1'b1;
        clockSource = `CLK_SEL_TMR;
      end
      `MODE_SPI_HDIV: begin
        isSpi = 1'b1;
        isSpiHost = 1'b1;
        clockSource = `CLK_SEL_BAUD;
      end
      `MODE_SPI_C_SS: begin
        isSpi = 1'b1;
        isSpiClient = 1'b1;
        slaveSelectUsed = 1'b1;
        clockSource = `CLK_SEL_PIN;
      end
      `MODE_SPI_C: begin
        isSpi = 1'b1;
        isSpiClient = 1'b1;
        clockSource = `CLK_SEL_PIN;
      end
      `MODE_I2C_C7: isI2cClient = 1'b1;
      `MODE_I2C_C10: begin
        isI2cClient = 1'b1;
        isTenBit = 1'b1;
      end
      `MODE_I2C_C7SP: begin
        isI2cClient = 1'b1;
        startStopIrq = 1'b1;
      end
      `MODE_I2C_C10SP: begin
        isI2cClient = 1'b1;
        isTenBit = 1'b1;
        startStopIrq = 1'b1;
      end
      `MODE_I2C_H: begin
        isI2cHost = 1'b1;
        clockSource = `CLK_SEL_BAUD;
      end
      `MODE_I2C_FW: isI2cHost = 1'b1;
      default: isReserved = 1'b1;
    endcase
  end
endmodule

// file: rtl/sync_serial_status_control.v
// Status and control register bank of the synchronous serial port.
//
// Overview of operation
// - Ten-bit client flags address reload need.
// - Transmit buffer-full high until transmit completes or the buffer is read.
// - Receive sets buffer-full on completed byte.
// - Receive completion counts data bits only.
// - Start/stop flags cleared by reset, disable.
// - Client direction bit latched at address match.
// - Active is OR of I2C host-transmit and requests.
// - Buffer write during transmit sets collision bit.
// - SPI client overflow drops new shifted byte.
// - I2C receive overflow sticks until software clears.
// - Enable bit hands pins to serial port.
// - SPI clock idle level follows clock bit.
// - Client clock bit zero stretches clock.
// - Codes 1111/1110 select client with interrupts.
// - Code 1011 is firmware-driven host.
// - Codes 0101/0100 are SPI client modes.
// - Codes 0000-0011 are SPI host clocks.
// - Code 1010 uses baud divider, nonzero.
// - Host modes never set overflow.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "serial_port_map.vh"
module sync_serial_status_control (
  // Clock, reset and clock enable.
  input wire clock,
  input wire sys_rst,
  input wire clkEn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Events from the shifter and bus logic.
  input wire txStart,
  input wire txDone,
  input wire rxByteDone,
  input wire bufferRead,
  input wire bufferWrite,
  input wire startSeen,
  input wire stopSeen,
  input wire nackSeen,
  input wire addrMatch,
  input wire addrRwBit,
  input wire addrHighByte,
  input wire addrLowDone,
  input wire [4:0] requestClear,
  // Port controls.
  output reg portEnabled,
  output reg sckIdleHigh,
  output reg clockHoldLow,
  output reg [2:0] clockSourceSel,
  output reg slaveSelectOn,
  output reg rxDiscard,
  output reg portActive,
  output reg [3:0] modeOut
);
  reg [7:0] ctrlOne_ff;
  reg [7:0] nxt_ctrlOne;
  reg [4:0] requests_ff;
  reg [4:0] nxt_requests;
  reg bufFull_ff;
  reg txBusy_ff;
  reg addrUpdate_ff;
  reg startDet_ff;
  reg stopDet_ff;
  reg rwBit_ff;
  reg wcolEvt;
  reg ovfEvt;
  wire isSpi;
  wire isSpiHost;
  wire isSpiClient;
  wire ssUsed;
  wire isI2cHost;
  wire isI2cClient;
  wire isTenBit;
  wire ssIrq;
  wire isReserved;
  wire [2:0] clkSrc;
  wire access;
  wire wrCtrl1;
  wire wrCtrl2;
  wire isHost;
  wire enabled;
  wire [7:0] statusByte;

  function hitAddr;
    input [11:0] addr;
    input [11:0] target;
    begin
      hitAddr = (addr == target);
    end
  endfunction

  port_mode_decode modeDec (
    .portModeSelect(ctrlOne_ff[3:0]),
    .isSpi(isSpi),
    .isSpiHost(isSpiHost),
    .isSpiClient(isSpiClient),
    .slaveSelectUsed(ssUsed),
    .isI2cHost(isI2cHost),
    .isI2cClient(isI2cClient),
    .isTenBit(isTenBit),
    .startStopIrq(ssIrq),
    .isReserved(isReserved),
    .clockSource(clkSrc)
  );

  // Single-wait APB: access phase answers on its second cycle.
  assign access = psel && penable && !pready;
  assign wrCtrl1 = access && pwrite && hitAddr(paddr, `OFF_CTRL1);
  assign wrCtrl2 = access && pwrite && hitAddr(paddr, `OFF_CTRL2);
  assign isHost = isSpiHost || isI2cHost;
  assign enabled = ctrlOne_ff[`BIT_EN];
  // I2C host transmit status shares the direction bit position.
  assign statusByte = {3'h0, stopDet_ff, startDet_ff,
                       (isI2cHost ? txBusy_ff : rwBit_ff), addrUpdate_ff, bufFull_ff};

  always @* begin
    // Collision: buffer written while the previous word still shifts.
    wcolEvt = enabled && bufferWrite && txBusy_ff;
    // Overflow only where the far side clocks bytes in; hosts start every transfer.
    ovfEvt = enabled && rxByteDone && bufFull_ff && !isHost && !isReserved;
    nxt_ctrlOne = ctrlOne_ff;
    if (wrCtrl1) begin
      nxt_ctrlOne = pwdata[7:0];
      // Software may only clear the sticky flags, never set them.
      nxt_ctrlOne[`BIT_WRITE_COLLISION_FLAG] = ctrlOne_ff[`BIT_WRITE_COLLISION_FLAG] & pwdata[`BIT_WRITE_COLLISION_FLAG];
      nxt_ctrlOne[`BIT_OVF] = ctrlOne_ff[`BIT_OVF] & pwdata[`BIT_OVF];
    end
    // A set arriving with a clear wins.
    if (wcolEvt) begin
      nxt_ctrlOne[`BIT_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (ovfEvt) begin
      nxt_ctrlOne[`BIT_OVF] = 1'b1;
    end
    nxt_requests = requests_ff & ~requestClear;
    if (wrCtrl2) begin
      nxt_requests = {pwdata[`BIT_ACK_SEQUENCE_REQUEST_BIT], pwdata[`BIT_RECEIVE_REQUEST_BIT], pwdata[`BIT_PEN],
                      pwdata[`BIT_REPEATED_START_REQUEST_BIT], pwdata[`BIT_SEN]};
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ctrlOne_ff <= `CTRL1_RESET;
      requests_ff <= 5'h00;
      bufFull_ff <= 1'b0;
      txBusy_ff <= 1'b0;
      addrUpdate_ff <= 1'b0;
      startDet_ff <= 1'b0;
      stopDet_ff <= 1'b0;
      rwBit_ff <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      portEnabled <= 1'b0;
      sckIdleHigh <= 1'b0;
      clockHoldLow <= 1'b0;
      clockSourceSel <= `CLK_SEL_NONE;
      slaveSelectOn <= 1'b0;
      rxDiscard <= 1'b0;
      portActive <= 1'b0;
      modeOut <= 4'h0;
    end else if (clkEn) begin
      ctrlOne_ff <= nxt_ctrlOne;
      requests_ff <= nxt_requests;
      pready <= access;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (access && !pwrite) begin
        // Status register is read-only; writes to it land nowhere.
        if (hitAddr(paddr, `OFF_STATUS)) begin
          prdata <= {24'h00_0000, statusByte};
        end else if (hitAddr(paddr, `OFF_CTRL1)) begin
          prdata <= {24'h00_0000, ctrlOne_ff};
        end else if (hitAddr(paddr, `OFF_CTRL2)) begin
          prdata <= {24'h00_0000, 3'h0, requests_ff[4], requests_ff[3:0]};
        end else begin
          pslverr <= 1'b1;
        end
      end else if (access && !hitAddr(paddr, `OFF_CTRL1) && !hitAddr(paddr, `OFF_CTRL2)
                   && !hitAddr(paddr, `OFF_STATUS)) begin
        pslverr <= 1'b1;
      end
      if (!enabled) begin
        // Clearing the enable drops all status-register flags; pending requests are kept.
        startDet_ff <= 1'b0;
        stopDet_ff <= 1'b0;
        bufFull_ff <= 1'b0;
        txBusy_ff <= 1'b0;
        addrUpdate_ff <= 1'b0;
        rwBit_ff <= 1'b0;
      end else begin
        if (startSeen) begin
          startDet_ff <= 1'b1;
          stopDet_ff <= 1'b0;
        end else if (stopSeen) begin
          stopDet_ff <= 1'b1;
          startDet_ff <= 1'b0;
        end
        if (txStart && !txBusy_ff) begin
          txBusy_ff <= 1'b1;
          bufFull_ff <= 1'b1;
        end else if (txDone) begin
          txBusy_ff <= 1'b0;
          bufFull_ff <= 1'b0;
        end else if (rxByteDone && !bufFull_ff) begin
          // rxByteDone pulses after the eighth data bit, before acknowledge.
          bufFull_ff <= 1'b1;
        end else if (bufferRead) begin
          bufFull_ff <= 1'b0;
        end
        if (isI2cClient && isTenBit && (addrHighByte || addrLowDone)) begin
          addrUpdate_ff <= 1'b1;
        end else if (bufferWrite && isI2cClient) begin
          addrUpdate_ff <= 1'b0;
        end
        if (isI2cClient && addrMatch) begin
          rwBit_ff <= addrRwBit;
        end else if (startSeen || stopSeen || nackSeen) begin
          rwBit_ff <= 1'b0;
        end
      end
      // All pin controls follow the stored register so mode and level change together.
      portEnabled <= enabled;
      sckIdleHigh <= isSpi && ctrlOne_ff[`BIT_CKP];
      // Stretch only as a client; a host ignores the bit.
      clockHoldLow <= enabled && isI2cClient && !ctrlOne_ff[`BIT_CKP];
      clockSourceSel <= clkSrc;
      slaveSelectOn <= enabled && isSpiClient && ssUsed;
      rxDiscard <= ovfEvt && isSpiClient;
      portActive <= (isI2cHost && txBusy_ff) || (|requests_ff);
      modeOut <= ctrlOne_ff[3:0];
    end
  end
endmodule

// file: testbench/ssc_asserts.sv
// Concurrent checks on the serial port register bank.
`timescale 1ns/1ps
module ssc_asserts (
  // Clock and reset.
  input wire clock,
  input wire sys_rst,
  // Register bus.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Port controls.
  input wire portEnabled,
  input wire clockHoldLow,
  input wire [2:0] clockSourceSel,
  input wire slaveSelectOn,
  input wire rxDiscard,
  input wire portActive,
  input wire [3:0] modeOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable && pready;
  wire [3:0] wrMode = pwdata[3:0];
  wire wrEn = pwdata[5];
  AST_READY_LATE: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_UNMAPPED_ERR: assert property (acc && !(paddr inside {12'h018F, 12'h0190, 12'h0191}) |-> pslverr)
    else $error("unmapped access not refused");
  AST_CTRL_WRITE: assert property (acc && pwrite && paddr == 12'h0190 |=> modeOut == $past(wrMode) && portEnabled == $past(wrEn))
    else $error("control write not applied");
  AST_HOLD_CLIENT: assert property (clockHoldLow |-> modeOut inside {4'h6, 4'h7, 4'hE, 4'hF})
    else $error("clock held outside client mode");
  AST_SS_MODE: assert property (slaveSelectOn |-> modeOut == 4'h4)
    else $error("select pin used in wrong mode");
  AST_NO_HOST_OVF: assert property (rxDiscard |-> !(modeOut inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hA, 4'hB}))
    else $error("overflow discard in host mode");
  AST_ACTIVE_REQ: assert property (acc && pwrite && paddr == 12'h0191 && pwdata[4:0] != 5'h00 |-> ##[1:2] portActive)
    else $error("request not shown as active");
  AST_RESET_STATE: assert property ($fell(sys_rst) |-> !portEnabled && modeOut == 4'h0 && clockSourceSel == 3'h7)
    else $error("outputs not at reset state");
endmodule
bind sync_serial_status_control ssc_asserts u_ssc_asserts (.clock(clock), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .portEnabled(portEnabled), .clockHoldLow(clockHoldLow),
  .clockSourceSel(clockSourceSel), .slaveSelectOn(slaveSelectOn), .rxDiscard(rxDiscard),
  .portActive(portActive), .modeOut(modeOut));

// file: testbench/serial_peer.sv
// Behavioural serial peer: turns event requests into one-cycle pulses.
`timescale 1ns/1ps
module serial_peer (
  // Clock.
  input wire clock,
  // Requests from the bench.
  input wire evValid,
  input wire [3:0] evCode,
  // Event pulses toward the port.
  output reg [10:0] evPulse
);
  initial evPulse = 11'h000;
  // A byte event marks a finished data byte only, never ack or stop.
  always @(posedge clock) begin
    evPulse <= evValid ? (11'h001 << evCode) : 11'h000;
  end
endmodule

// file: testbench/tb.sv
// Self-checking bench of the serial port register bank.
`timescale 1ns/1ps
`define CHK(n, e, a) begin nChecks++; if ((a) !== (e)) begin failCount++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb;
  logic clock, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr, er, evValid, addrRwBit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] evCode, modeOut;
  logic [4:0] requestClear;
  logic [10:0] ev;
  logic portEnabled, sckIdleHigh, clockHoldLow, slaveSelectOn, rxDiscard, portActive, ck, seen;
  logic [2:0] clockSourceSel;
  // Reserved codes 1100 and 1101 are never programmed.
  logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hA};
  int failCount, nChecks;
  serial_peer peer (.clock(clock), .evValid(evValid), .evCode(evCode), .evPulse(ev));
  sync_serial_status_control dut (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txStart(ev[0]), .txDone(ev[1]),
    .rxByteDone(ev[2]), .bufferRead(ev[3]), .bufferWrite(ev[4]), .startSeen(ev[5]),
    .stopSeen(ev[6]), .nackSeen(ev[7]), .addrMatch(ev[8]), .addrRwBit(addrRwBit),
    .addrHighByte(ev[9]), .addrLowDone(ev[10]), .requestClear(requestClear),
    .portEnabled(portEnabled), .sckIdleHigh(sckIdleHigh), .clockHoldLow(clockHoldLow),
    .clockSourceSel(clockSourceSel), .slaveSelectOn(slaveSelectOn), .rxDiscard(rxDiscard),
    .portActive(portActive), .modeOut(modeOut));
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (rxDiscard) seen <= 1;
  function automatic logic [2:0] src(input logic [3:0] m);
    if (m == 4'hA) return 3'h4;
    if (m[2]) return 3'h5;
    return m[2:0];
  endfunction
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (!pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic ctl(input logic [7:0] v);
    bus(1, 12'h0190, {24'h00_0000, v});
    repeat (2) @(posedge clock);
  endtask
  task automatic pulse(input int n);
    evCode <= n[3:0];
    evValid <= 1;
    @(posedge clock);
    evValid <= 0;
    repeat (4) @(posedge clock);
  endtask
  task automatic reportAndStop;
    $display("checks %0d failures %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {sys_rst, clkEn} = 2'b11;
    {psel, penable, pwrite, evValid, addrRwBit, seen} = 0;
    {paddr, pwdata, evCode, requestClear} = 0;
    void'($urandom(32'hab59));
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    bus(0, 12'h0190, 0);
    `CHK("ctrl reset", 8'h00, rd[7:0])
    bus(1, 12'h018F, 32'h0000_00FF);
    bus(0, 12'h018F, 0);
    `CHK("status ro", 8'h00, rd[7:0])
    bus(1, 12'h01A0, $urandom);
    `CHK("unmapped", 1'b1, er)
    foreach (codes[i]) begin
      ck = $urandom;
      ctl({3'b001, ck, codes[i]});
      `CHK("clock source", src(codes[i]), clockSourceSel)
      `CHK("select", codes[i] == 4'h4, slaveSelectOn)
      `CHK("idle high", ck, sckIdleHigh)
    end
    $display("mode test done");
    ctl(8'h20);
    pulse(0);
    pulse(4);
    pulse(2);
    pulse(2);
    bus(0, 12'h0190, 0);
    `CHK("write_collision_flag set no ovf", 2'b10, rd[7:6])
    ctl(8'h20);
    bus(0, 12'h0190, 0);
    `CHK("write_collision_flag cleared", 1'b0, rd[7])
    ctl(8'h25);
    pulse(3); // Software drains the buffer before the next byte.
    seen = 0;
    pulse(2);
    pulse(2);
    bus(0, 12'h018F, 0);
    `CHK("full", 1'b1, rd[0])
    bus(0, 12'h0190, 0);
    `CHK("ovf", 1'b1, rd[6])
    `CHK("discard", 1'b1, seen)
    $display("flag test done");
    ctl(8'h26);
    `CHK("hold low", 1'b1, clockHoldLow)
    addrRwBit <= 1;
    pulse(5);
    pulse(8);
    bus(0, 12'h018F, 0);
    `CHK("start rw", 2'b11, rd[3:2])
    ctl(8'h36);
    `CHK("release", 1'b0, clockHoldLow)
    ctl(8'h16);
    bus(0, 12'h018F, 0);
    `CHK("disable clears", 2'b00, rd[4:3])
    ctl(8'h28);
    `CHK("host ignores", 1'b0, clockHoldLow)
    bus(1, 12'h0191, 32'h0000_0001);
    `CHK("active", 1'b1, portActive)
    clkEn <= 0;
    requestClear <= 5'h01;
    @(posedge clock);
    requestClear <= 5'h00;
    clkEn <= 1;
    repeat (2) @(posedge clock);
    `CHK("frozen", 1'b1, portActive)
    requestClear <= 5'h01;
    @(posedge clock);
    requestClear <= 5'h00;
    repeat (2) @(posedge clock);
    `CHK("idle", 1'b0, portActive)
    $display("i2c test done");
    reportAndStop;
  end
  initial begin
    #100000;
    failCount++;
    reportAndStop;
  end
endmodule
